/* File: logic/cts_sequencer.sv */
// zero/one-cycle fault locating test sequencer
//
// Operation
// [RULE1] run each test from 22 words, in order
// [RULE2] scan-in uses words 1-11, address steps only
// [RULE3] word 12 loads microaddress, counter, flags
// [RULE4] word 12 bits: counter, flag bits 4-7
// [RULE5] advance: execute, step counter until seven
// [RULE6] counter reaching seven forces address 2C0
// [RULE7] control word 000 marks zero-cycle test
// [RULE8] zero-cycle trigger patterns: clear, set, clear
// [RULE9] one-cycle transfer takes one or two cycles
// [RULE10] store words 13, 14 at 80, 84
// [RULE11] store 14 state, 17 channel words
// [RULE12] mask OR actual versus expected, sticky triggers
// [RULE13] count passes, repeat test, branch after 16
// [RULE14] both triggers on: stop, intermittent fault
// [RULE15] both triggers off: stop, checker fault
// [RULE16] start at off-off stop forces pass
// [RULE17] words 15-22: mask, expected, addresses, ids
// [RULE18] scan-in via bus, scan-out via data reg
// [RULE19] new test clears triggers and pass counter
`timescale 1ns/100ps
`include "cts_params.svh"

module cts_sequencer
   import cts_pkg::*;
#(
   parameter int AW = 24
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          nrst,
   // operator controls
   input  wire logic          start,
   input  wire logic [AW-1:0] test_addr,
   input  wire logic          force_pass_sw,
   // main storage port
   output logic               mem_req,
   output logic               mem_we,
   output logic [AW-1:0]      mem_addr,
   output logic [31:0]        mem_wdata,
   input  wire logic [31:0]   mem_rdata,
   input  wire logic          mem_ack,
   // scan-in bus to triggers
   output logic               scan_in_valid_ff,
   output logic [4:0]         scan_in_idx_ff,
   output logic [31:0]        scan_in_data_ff,
   // scan bus from triggers and channels
   output logic [4:0]         scan_out_idx,
   input  wire logic [31:0]   scan_out_data,
   // control store
   output logic               cs_exec,
   output logic [11:0]        microaddress_register_ff,
   input  wire logic [31:0]   cs_word,
   input  wire logic [11:0]   cs_next_addr,
   // status
   output logic [2:0]         seq_ctr_ff,
   output logic               supervisory_flag_ff,
   output logic               progressive_scan_flag_ff,
   output logic               supervisory_enable_storage_flag_ff,
   output logic               io_mode_flag_ff,
   output logic               zero_cycle_ff,
   output logic               pass_trig_ff,
   output logic               fail_trig_ff,
   output logic [3:0]         scan_test_cnt_ff,
   output logic [31:0]        storage_data_reg_ff,
   output logic [AW-1:0]      instruction_address_reg_ff,
   output logic               stopped,
   output logic               busy
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   cts_state_type   state_ff;
   logic            ph_ff;
   logic [4:0]      wcnt_ff;
   logic [AW-1:0]   base_ff;
   logic [4:0]      resp_sel_ff;
   logic [31:0]     actual_ff;
   logic [31:0]     prog_ff [`CTS_W_MASK:`CTS_W_LAST];
   logic            rd_done;
   logic            wr_done;
   logic            match;
   logic [AW-1:0]   wr_addr;
   logic [AW-1:0]   so_off;
   logic [AW-1:0]   next_test;

   assign rd_done = mem_req && !mem_we && mem_ack;
   assign wr_done = mem_req && mem_we && mem_ack;
   // mask forces don't-care bits of the actual word to one; expected is used as read
   assign match   = ((prog_ff[`CTS_W_MASK] | actual_ff)
                     == prog_ff[`CTS_W_EXP]); // RULE12
   assign stopped = (state_ff == CTS_STOP);
   assign busy    = (state_ff != CTS_IDLE) && !stopped;
   assign cs_exec = (state_ff == CTS_ADV);
   assign scan_out_idx = wcnt_ff;

   // ---------------------------------------------------------------
   // storage port
   // ---------------------------------------------------------------
   always_comb begin
      so_off = AW'({wcnt_ff, 2'b00});
      if (state_ff == CTS_SOCOPY) begin
         wr_addr = (wcnt_ff == `CTS_W_COPY1) ? `CTS_A_COPY1
                                             : `CTS_A_COPY2; // RULE10
      end else if (wcnt_ff < `CTS_SO_CHAN) begin
         wr_addr = `CTS_A_REGS + so_off; // RULE11
      end else begin
         wr_addr = `CTS_A_CHAN + so_off - AW'({`CTS_SO_CHAN, 2'b00});
      end
   end

   always_comb begin
      mem_req = 1'b0;
      mem_we  = 1'b0;
      unique case (state_ff)
         CTS_SCANIN, CTS_LCW, CTS_CMPRD: mem_req = 1'b1;
         CTS_SOCOPY: begin
            mem_req = 1'b1;
            mem_we  = ph_ff;
         end
         CTS_SOSTATE: begin
            mem_req = ph_ff;
            mem_we  = ph_ff;
         end
         default: ;
      endcase
   end

   assign mem_addr  = mem_we ? wr_addr : instruction_address_reg_ff;
   assign mem_wdata = storage_data_reg_ff; // RULE18

   // ---------------------------------------------------------------
   // sequencing
   // ---------------------------------------------------------------
   always_comb begin
      next_test = prog_ff[`CTS_W_NEXT][AW-1:0];
      if (!pass_trig_ff && !fail_trig_ff) begin
         next_test = prog_ff[`CTS_W_FORCED][AW-1:0]; // RULE16
      end else if (stopped && force_pass_sw) begin
         next_test = prog_ff[`CTS_W_FORCED][AW-1:0];
      end else if (stopped) begin
         next_test = prog_ff[`CTS_W_RESTART][AW-1:0];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= CTS_IDLE;
         ph_ff    <= 1'b0;
         wcnt_ff  <= `CTS_W_FIRST;
      end else begin
         unique case (state_ff)
            CTS_IDLE, CTS_STOP: begin
               if (start) begin
                  state_ff <= CTS_SCANIN;
                  wcnt_ff  <= `CTS_W_FIRST;
               end
            end
            CTS_SCANIN: begin
               if (rd_done) begin // RULE1
                  if (wcnt_ff == `CTS_W_SCAN_LAST) begin
                     state_ff <= CTS_LCW;
                  end
                  wcnt_ff <= wcnt_ff + 5'h01;
               end
            end
            CTS_LCW: begin
               if (rd_done) begin
                  wcnt_ff  <= `CTS_W_COPY1;
                  state_ff <= (mem_rdata[`CTS_LCW_SEQ] == `CTS_SEQ_DONE)
                              ? CTS_SOCOPY : CTS_ADV;
               end
            end
            CTS_ADV: begin
               if (seq_ctr_ff == `CTS_SEQ_LAST) begin
                  state_ff <= CTS_SOCOPY; // RULE9
               end
            end
            CTS_SOCOPY: begin
               if (rd_done) begin
                  ph_ff <= 1'b1;
               end else if (wr_done) begin
                  ph_ff <= 1'b0;
                  if (wcnt_ff == `CTS_W_COPY2) begin
                     state_ff <= CTS_SOSTATE;
                     wcnt_ff  <= `CTS_SO_FIRST;
                  end else begin
                     wcnt_ff <= `CTS_W_COPY2;
                  end
               end
            end
            CTS_SOSTATE: begin
               if (!ph_ff) begin
                  ph_ff <= 1'b1;
               end else if (wr_done) begin
                  ph_ff <= 1'b0;
                  if (wcnt_ff == `CTS_SO_LAST) begin
                     state_ff <= CTS_CMPRD;
                     wcnt_ff  <= `CTS_W_MASK;
                  end else begin
                     wcnt_ff <= wcnt_ff + 5'h01;
                  end
               end
            end
            CTS_CMPRD: begin
               if (rd_done) begin // RULE17
                  if (wcnt_ff == `CTS_W_LAST) begin
                     state_ff <= CTS_CMP;
                  end else begin
                     wcnt_ff <= wcnt_ff + 5'h01;
                  end
               end
            end
            CTS_CMP: begin
               wcnt_ff  <= `CTS_W_FIRST;
               state_ff <= (scan_test_cnt_ff == `CTS_PASS_LAST)
                           ? CTS_BRANCH : CTS_SCANIN; // RULE13
            end
            CTS_BRANCH: begin
               if (pass_trig_ff && !fail_trig_ff) begin
                  state_ff <= CTS_SCANIN;
               end else begin
                  state_ff <= CTS_STOP; // RULE14 RULE15
               end
            end
            default: state_ff <= CTS_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // program addressing
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         instruction_address_reg_ff <= '0;
         base_ff <= '0;
      end else if (start && state_ff == CTS_IDLE) begin
         instruction_address_reg_ff <= test_addr;
         base_ff <= test_addr;
      end else if ((start && stopped) || (state_ff == CTS_BRANCH &&
                   pass_trig_ff && !fail_trig_ff)) begin
         instruction_address_reg_ff <= next_test;
         base_ff <= next_test;
      end else if (state_ff == CTS_CMP) begin
         instruction_address_reg_ff <= base_ff;
      end else if (rd_done) begin
         instruction_address_reg_ff <=
            instruction_address_reg_ff + `CTS_A_STEP; // RULE2
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         storage_data_reg_ff <= '0;
      end else if (rd_done) begin
         storage_data_reg_ff <= mem_rdata;
      end else if (state_ff == CTS_SOSTATE && !ph_ff) begin
         storage_data_reg_ff <= scan_out_data; // RULE18
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         resp_sel_ff <= '0;
         actual_ff   <= '0;
      end else if (state_ff == CTS_SOCOPY && rd_done &&
                   wcnt_ff == `CTS_W_COPY1) begin
         resp_sel_ff <= mem_rdata[`CTS_SEL_BITS];
      end else if (state_ff == CTS_SOSTATE && !ph_ff &&
                   wcnt_ff == resp_sel_ff) begin
         actual_ff <= scan_out_data;
      end
   end

   always_ff @(posedge clk) begin
      if (state_ff == CTS_CMPRD && rd_done) begin
         prog_ff[wcnt_ff] <= mem_rdata;
      end
   end

   // scan-in drives values onto the triggers, trigger patterns included
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scan_in_valid_ff <= 1'b0;
         scan_in_idx_ff   <= '0;
         scan_in_data_ff  <= '0;
      end else begin
         scan_in_valid_ff <= (state_ff == CTS_SCANIN) && rd_done; // RULE8
         if (state_ff == CTS_SCANIN && rd_done) begin
            scan_in_idx_ff  <= wcnt_ff;
            scan_in_data_ff <= mem_rdata; // RULE18
         end
      end
   end

   // ---------------------------------------------------------------
   // linkage control word and clock advance
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         microaddress_register_ff           <= '0;
         seq_ctr_ff                         <= '0;
         supervisory_flag_ff                <= 1'b0;
         progressive_scan_flag_ff           <= 1'b0;
         supervisory_enable_storage_flag_ff <= 1'b0;
         io_mode_flag_ff                    <= 1'b0;
      end else if (state_ff == CTS_LCW && rd_done) begin
         seq_ctr_ff <= mem_rdata[`CTS_LCW_SEQ]; // RULE4
         supervisory_flag_ff                <= 1'b1; // RULE3
         progressive_scan_flag_ff           <= 1'b0;
         supervisory_enable_storage_flag_ff <= 1'b0;
         io_mode_flag_ff <= mem_rdata[`CTS_LCW_IO];
         microaddress_register_ff <=
            (mem_rdata[`CTS_LCW_SEQ] == `CTS_SEQ_DONE) ? `CTS_HW_SCANOUT
                                                : mem_rdata[`CTS_LCW_UADDR];
      end else if (state_ff == CTS_ADV) begin
         seq_ctr_ff <= seq_ctr_ff + 3'h1; // RULE5
         microaddress_register_ff <= (seq_ctr_ff == `CTS_SEQ_LAST)
                            ? `CTS_HW_SCANOUT : cs_next_addr; // RULE6
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         zero_cycle_ff <= 1'b0;
      end else if (state_ff == CTS_LCW) begin
         zero_cycle_ff <= 1'b1;
      end else if (state_ff == CTS_ADV && cs_word != `CTS_ZERO_WORD) begin
         zero_cycle_ff <= 1'b0; // RULE7
      end
   end

   // ---------------------------------------------------------------
   // compare and pass/fail triggers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pass_trig_ff     <= 1'b0;
         fail_trig_ff     <= 1'b0;
         scan_test_cnt_ff <= '0;
      end else if ((start && (state_ff == CTS_IDLE || stopped)) ||
                   (state_ff == CTS_BRANCH && pass_trig_ff &&
                    !fail_trig_ff)) begin
         pass_trig_ff     <= 1'b0; // RULE19
         fail_trig_ff     <= 1'b0;
         scan_test_cnt_ff <= '0;
      end else if (state_ff == CTS_CMP) begin
         pass_trig_ff     <= pass_trig_ff | match; // RULE12
         fail_trig_ff     <= fail_trig_ff | !match;
         scan_test_cnt_ff <= scan_test_cnt_ff + 4'h1; // RULE13
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence adv_last_s;
      state_ff == CTS_ADV && seq_ctr_ff == `CTS_SEQ_LAST;
   endsequence

   sequence enter_scanout_s;
      microaddress_register_ff == `CTS_HW_SCANOUT &&
      seq_ctr_ff == `CTS_SEQ_DONE && state_ff == CTS_SOCOPY;
   endsequence

   lcw_flags_a: assert property ( // RULE3
      state_ff == CTS_LCW && rd_done |=> supervisory_flag_ff &&
      !progressive_scan_flag_ff && !supervisory_enable_storage_flag_ff &&
      io_mode_flag_ff == $past(mem_rdata[`CTS_LCW_IO]))
      else $error("lcw flags wrong");

   seq_step_a: assert property ( // RULE5
      state_ff == CTS_ADV |=> seq_ctr_ff == $past(seq_ctr_ff) + 3'h1)
      else $error("sequence counter did not step");

   hw_addr_a: assert property ( // RULE6
      adv_last_s |=> enter_scanout_s)
      else $error("scan-out address not forced");

   iar_step_a: assert property ( // RULE2
      state_ff == CTS_SCANIN && rd_done |=> instruction_address_reg_ff
      == $past(instruction_address_reg_ff) + `CTS_A_STEP)
      else $error("address not advanced");

   copy_dst_a: assert property ( // RULE10
      state_ff == CTS_SOCOPY && mem_we |->
      mem_addr == `CTS_A_COPY1 || mem_addr == `CTS_A_COPY2)
      else $error("copy address wrong");

   chan_dst_a: assert property ( // RULE11
      state_ff == CTS_SOSTATE && mem_we && wcnt_ff == `CTS_SO_CHAN
      |-> mem_addr == `CTS_A_CHAN)
      else $error("channel status address wrong");

   fail_set_a: assert property ( // RULE12
      state_ff == CTS_CMP && !match |=> fail_trig_ff ##1 fail_trig_ff)
      else $error("fail trigger not held");

   pass16_a: assert property ( // RULE13
      state_ff == CTS_CMP && scan_test_cnt_ff == `CTS_PASS_LAST
      |=> state_ff == CTS_BRANCH)
      else $error("no branch after last pass");

   stop_both_a: assert property ( // RULE14
      state_ff == CTS_BRANCH && pass_trig_ff && fail_trig_ff
      |=> stopped && pass_trig_ff && fail_trig_ff)
      else $error("intermittent stop missing");

   force_pass_a: assert property ( // RULE16
      stopped && start && !pass_trig_ff && !fail_trig_ff |=>
      instruction_address_reg_ff == $past(prog_ff[`CTS_W_FORCED][AW-1:0])
      && state_ff == CTS_SCANIN)
      else $error("forced pass not taken");

endmodule : cts_sequencer

/* File: logic/cts_params.svh */
// constants for the cycle test sequencer
`ifndef CTS_PARAMS_SVH
`define CTS_PARAMS_SVH
// program word numbers (1-based)
`define CTS_W_FIRST     5'h01
`define CTS_W_SCAN_LAST 5'h0B
`define CTS_W_COPY1     5'h0D
`define CTS_W_COPY2     5'h0E
`define CTS_W_MASK      5'h0F
`define CTS_W_EXP       5'h10
`define CTS_W_NEXT      5'h12
`define CTS_W_RESTART   5'h14
`define CTS_W_FORCED    5'h15
`define CTS_W_LAST      5'h16
// scan-out word indexes
`define CTS_SO_FIRST    5'h00
`define CTS_SO_CHAN     5'h0E
`define CTS_SO_LAST     5'h1E
// fixed storage addresses
`define CTS_A_COPY1     24'h00_0080
`define CTS_A_COPY2     24'h00_0084
`define CTS_A_REGS      24'h00_0088
`define CTS_A_CHAN      24'h00_00C0
`define CTS_A_STEP      24'h00_0004
// linkage control word fields
`define CTS_LCW_SEQ     31:29
`define CTS_LCW_IO      24
`define CTS_LCW_UADDR   12:1
`define CTS_SEL_BITS    4:0
// sequencing constants
`define CTS_HW_SCANOUT  12'h2C0
`define CTS_SEQ_DONE    3'h7
`define CTS_SEQ_LAST    3'h6
`define CTS_PASS_LAST   4'hF
`define CTS_ZERO_WORD   32'h0000_0000
`endif

/* File: logic/cts_pkg.sv */
// types for the cycle test sequencer
package cts_pkg;
   typedef enum logic [3:0] {
      CTS_IDLE    = 4'b0000,
      CTS_SCANIN  = 4'b0001,
      CTS_LCW     = 4'b0010,
      CTS_ADV     = 4'b0011,
      CTS_SOCOPY  = 4'b0100,
      CTS_SOSTATE = 4'b0101,
      CTS_CMPRD   = 4'b0110,
      CTS_CMP     = 4'b0111,
      CTS_BRANCH  = 4'b1000,
      CTS_STOP    = 4'b1001
   } cts_state_type;
endpackage : cts_pkg

/* File: tb/cts_storage_model.sv */
// main storage model answering the sequencer's word accesses
`timescale 1ns/100ps

module cts_storage_model (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // access port
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [23:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   output logic      [31:0] mem_rdata,
   output logic             mem_ack,
   // answer delay in cycles
   input  wire logic [1:0]  lat
);
   logic [31:0] mem [0:255];
   logic [31:0] last_ff;
   logic [1:0]  wait_ff;

   assign mem_ack = mem_req && (wait_ff == lat);
   // released data lines show the inverse of the last word
   assign mem_rdata = (mem_ack && !mem_we) ? mem[mem_addr[9:2]] : ~last_ff;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wait_ff <= 2'h0;
         last_ff <= 32'h0000_0000;
      end else begin
         wait_ff <= (mem_req && !mem_ack) ? wait_ff + 2'h1 : 2'h0;
         if (mem_ack) begin
            last_ff <= mem_we ? mem_wdata : mem_rdata;
         end
      end
   end

   always @(posedge clk) begin
      if (mem_ack && mem_we) begin
         mem[mem_addr[9:2]] <= mem_wdata;
      end
   end
endmodule : cts_storage_model

/* File: tb/cts_sequencer_test.sv */
// self-checking bench for the cycle test sequencer
`timescale 1ns/100ps

module cts_sequencer_test;
   // ----
   // signals
   // ----
   logic        clk, nrst, start, force_pass_sw, tc_mode, exec_d;
   logic [1:0]  lat;
   logic [23:0] test_addr, mem_addr, instruction_address_reg;
   logic        mem_req, mem_we, mem_ack, scan_in_valid_ff, cs_exec;
   logic [31:0] mem_wdata, mem_rdata, scan_in_data_ff, scan_out_data;
   logic [31:0] cs_word, storage_data_reg;
   logic [4:0]  scan_in_idx_ff, scan_out_idx;
   logic [11:0] uaddr, cs_next_addr;
   logic [2:0]  seq;
   logic        ss, progressive_scan_flag, supervisory_enable_storage_flag, io, zc, pass_t, fail_t, stopped, busy;
   logic [3:0]  cnt;
   int          fail_count, total_checks, exec_n, s;
   logic [24:0] acc_q[$];
   logic [36:0] si_q[$];

   // scan bus and control store stand-ins
   assign scan_out_data = 32'h5A00_0000 | {27'h0, scan_out_idx}
                          | {23'h0, tc_mode & cnt[0], 8'h0};
   assign cs_word = (uaddr == 12'h045) ? 32'h0 : {20'h0_A000, uaddr};
   assign cs_next_addr = uaddr + 12'h001;

   cts_sequencer #(.AW(24)) dut (
      .clk(clk), .nrst(nrst), .start(start), .test_addr(test_addr),
      .force_pass_sw(force_pass_sw), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack), .scan_in_valid_ff(scan_in_valid_ff),
      .scan_in_idx_ff(scan_in_idx_ff), .scan_in_data_ff(scan_in_data_ff),
      .scan_out_idx(scan_out_idx), .scan_out_data(scan_out_data),
      .cs_exec(cs_exec), .microaddress_register_ff(uaddr),
      .cs_word(cs_word), .cs_next_addr(cs_next_addr), .seq_ctr_ff(seq),
      .supervisory_flag_ff(ss), .progressive_scan_flag_ff(progressive_scan_flag),
      .supervisory_enable_storage_flag_ff(supervisory_enable_storage_flag), .io_mode_flag_ff(io),
      .zero_cycle_ff(zc), .pass_trig_ff(pass_t), .fail_trig_ff(fail_t),
      .scan_test_cnt_ff(cnt), .storage_data_reg_ff(storage_data_reg),
      .instruction_address_reg_ff(instruction_address_reg), .stopped(stopped), .busy(busy));

   cts_storage_model sm (
      .clk(clk), .nrst(nrst), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack), .lat(lat));

   always #10 clk = ~clk;

   // ----
   // monitors
   // ----
   always @(posedge clk) begin
      if (mem_req && mem_ack) begin
         acc_q.push_back({mem_we, mem_addr});
      end
      if (scan_in_valid_ff) begin
         si_q.push_back({scan_in_idx_ff, scan_in_data_ff});
      end
      if (cs_exec) begin
         exec_n++;
      end
      if (exec_d && !cs_exec) begin
         check(37'({seq, uaddr}), 37'({3'h7, 12'h2C0}));
      end
      exec_d <= cs_exec;
   end

   // ----
   // tasks
   // ----
   task automatic summarize;
      $display("checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize

   task automatic check(input logic [36:0] got, input logic [36:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t: got %h, wanted %h", $time, got, exp);
      end
   endtask : check

   function automatic logic [31:0] pw(input logic [23:0] b, input int n);
      return sm.mem[b[9:2] + 8'(n - 1)];
   endfunction : pw

   task automatic load_prog(input logic [23:0] b, input logic [31:0] linkage_control_word,
         input logic [31:0] exp, input logic [23:0] nx, input logic [23:0] fp);
      logic [31:0] w [1:22];
      int n;
      for (n = 1; n <= 11; n++) begin
         w[n] = {b, 8'(n)};
      end
      w[12] = linkage_control_word;
      w[13] = 32'h0000_0003;
      w[14] = {b, 8'hEE};
      w[15] = 32'h0000_00FF;
      w[16] = exp;
      w[17] = {8'h0, b};
      w[18] = {8'h0, nx};
      w[19] = 32'h0100_0000;
      w[20] = {8'h0, b};
      w[21] = {8'h0, fp};
      w[22] = {b, 8'h22};
      for (n = 1; n <= 22; n++) begin
         sm.mem[b[9:2] + 8'(n - 1)] = w[n];
      end
   endtask : load_prog

   task automatic press(input logic [23:0] a);
      @(posedge clk);
      start <= 1'b1;
      test_addr <= a;
      @(posedge clk);
      start <= 1'b0;
      #1;
   endtask : press

   task automatic wait_stop;
      int n;
      for (n = 0; n < 8000 && stopped !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      if (stopped !== 1'b1) begin
         fail_count++;
         $display("ERROR at %0t: no stop", $time);
         summarize();
      end
   endtask : wait_stop

   // one pass: 13 reads, copies, 31 state writes, 8 compare reads
   task automatic chk_order(input int st, input logic [23:0] b);
      logic [24:0] e;
      int i;
      for (i = 0; i < 55; i++) begin
         if (i < 13) e = {1'b0, b + 24'(4 * i)};
         else if (i == 13) e = {1'b1, 24'h00_0080};
         else if (i == 14) e = {1'b0, b + 24'h00_0034};
         else if (i == 15) e = {1'b1, 24'h00_0084};
         else if (i < 47) e = {1'b1, 24'h00_0088 + 24'(4 * (i - 16))};
         else e = {1'b0, b + 24'(4 * (i - 33))};
         check(37'(acc_q[st + i]), 37'(e));
      end
   endtask : chk_order

   // ----
   // main sequence
   // ----
   initial begin
      clk = 0;
      nrst = 0;
      start = 0;
      force_pass_sw = 0;
      test_addr = 24'h0;
      lat = 2'h0;
      tc_mode = 0;
      exec_d = 0;
      load_prog(24'h200, 32'hAD00_0246, 32'h5A00_00FF, 24'h280, 24'h200);
      load_prog(24'h280, 32'hC000_008A, 32'h0000_0000, 24'h200, 24'h300);
      load_prog(24'h300, 32'hA000_0020, 32'h5A00_00FF, 24'h280, 24'h200);
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      press(24'h200);
      for (s = 0; s < 200 && cs_exec !== 1'b1; s++) begin
         @(posedge clk);
         #1;
      end
      if (cs_exec !== 1'b1) begin
         fail_count++;
         $display("ERROR at %0t: no clock advance", $time);
         summarize();
      end
      check(37'({seq, uaddr, io, ss, progressive_scan_flag, supervisory_enable_storage_flag}), 37'({15'h5123, 4'hC}));
      repeat (2) @(posedge clk);
      #1;
      check(37'(zc), 37'(0));
      wait_stop();
      check(37'(acc_q.size()), 37'(32 * 55));
      chk_order(0, 24'h200);
      chk_order(15 * 55, 24'h200);
      chk_order(16 * 55, 24'h280);
      chk_order(31 * 55, 24'h280);
      for (s = 0; s < 11; s++) begin
         check(si_q[s], {5'(s + 1), pw(24'h200, s + 1)});
      end
      check(37'(si_q.size()), 37'(32 * 11));
      check(37'(exec_n), 37'(48));
      check(37'({pass_t, fail_t, zc}), 37'(3'b011));
      check(37'(sm.mem[32]), 37'(pw(24'h280, 13)));
      check(37'(sm.mem[33]), 37'(pw(24'h280, 14)));
      for (s = 0; s < 31; s++) begin
         check(37'(sm.mem[34 + s]), 37'(32'h5A00_0000 | s));
      end
      @(posedge clk);
      lat <= 2'h2;
      tc_mode <= 1'b1;
      force_pass_sw <= 1'b1;
      s = acc_q.size();
      press(24'h0);
      wait_stop();
      check(37'(acc_q[s]), 37'(24'h300));
      check(37'({pass_t, fail_t}), 37'(2'b11));
      @(posedge clk);
      tc_mode <= 1'b0;
      force_pass_sw <= 1'b0;
      s = acc_q.size();
      press(24'h0);
      check(37'({busy, pass_t, fail_t, cnt}), 37'(7'h40));
      wait_stop();
      check(37'(acc_q[s]), 37'(24'h300));
      check(37'(acc_q[s + 16 * 55]), 37'(24'h280));
      check(37'({pass_t, fail_t}), 37'(2'b01));
      check(37'({busy, instruction_address_reg}), 37'({1'b0, 24'h00_0280}));
      check(37'(storage_data_reg), 37'(pw(24'h280, 22)));
      summarize();
   end
endmodule : cts_sequencer_test
